// >>> hdl/config_four_and_test_regs.sv
// apb register bank for shared alert pin, tach threshold and test registers
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "cfg4_regs_consts.svh"

// What this block does
// RULE1 - with the pin-function bit set the shared pin is an interrupt output for limit errors.
// RULE2 - with the pin-function bit clear the pin is the 2.5 V input and carries no alert.
// RULE3 - bits 3 to 2 pick the tach threshold of 20, 40, 80 or 130 mV.
// RULE4 - once the lock bit is set, writes to the configuration register have no effect.
// RULE5 - bit 1 and bits 7 to 4 are reserved, read-only and without function.
// RULE6 - the configuration register resets to all zeros.
// RULE7 - software should leave the two read-only zero-reset factory test registers alone.
// RULE8 - in alert mode the pin is pulled low open-drain while any enabled limit flag is set.
module config_four_and_test_regs
   import cfg4_regs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`LIMIT_WIDTH-1:0] limit_flags,
   input wire logic alert_pin_in,
   output logic alert_pin_out,
   output logic alert_pin_oe,
   output logic meas_2v5_enable,
   output logic [1:0] two_wire_tach_threshold,
   output logic [7:0] tach_threshold_mv,
   output logic irq
);

   apb_state_t state_reg;
   apb_state_t state_next;
   byte_t cfg4_reg;
   byte_t factory_test_one_reg;
   byte_t factory_test_two_reg;
   logic lock_reg;
   logic [`EVENT_WIDTH-1:0] mask_reg;
   logic [`EVENT_WIDTH-1:0] status_reg;
   logic [`EVENT_WIDTH-1:0] event_set;
   logic [`EVENT_WIDTH-1:0] event_clear;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic alert_oe_reg;
   logic meas_en_reg;
   logic [1:0] thr_reg;
   logic irq_reg;
   logic pin_level_reg;
   logic [9:0] reg_index;
   logic aligned;
   logic hit_cfg4;
   logic hit_test_one;
   logic hit_test_two;
   logic hit_lock;
   logic hit_status;
   logic hit_mask;
   logic mapped;
   logic access_phase;
   logic complete;
   logic wr_commit;
   logic lane0;
   logic lane1;
   logic cfg4_write;
   logic cfg4_blocked;
   logic [31:0] read_mux;
   logic pending;
   byte_t cfg4_merged;

   // address decode: word index plus alignment check
   assign reg_index = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign hit_cfg4 = aligned && (reg_index == `IDX_PIN_TACH_CFG);
   assign hit_test_one = aligned && (reg_index == `IDX_FACTORY_TEST_ONE);
   assign hit_test_two = aligned && (reg_index == `IDX_FACTORY_TEST_TWO);
   assign hit_lock = aligned && (reg_index == `IDX_LOCK_CONTROL);
   assign hit_status = aligned && (reg_index == `IDX_EVENT_STATUS);
   assign hit_mask = aligned && (reg_index == `IDX_EVENT_MASK);
   assign mapped = hit_cfg4 | hit_test_one | hit_test_two | hit_lock | hit_status | hit_mask;

   // transfer phases; a write lands only on the completing edge
   assign access_phase = psel && penable;
   assign complete = access_phase && (state_reg == st_ready);
   assign wr_commit = complete && pwrite && mapped;
   assign lane0 = pstrb[0];
   assign lane1 = pstrb[1];

   // the lock is checked at the commit edge, so a lock landing first wins
   assign cfg4_write = wr_commit && hit_cfg4 && lane0 && !lock_reg; // RULE4
   assign cfg4_blocked = wr_commit && hit_cfg4 && lane0 && lock_reg; // RULE4

   // only the documented fields take write data; reserved bits stay zero
   assign cfg4_merged = pwdata[7:0] & `CFG4_WMASK; // RULE5

   // apb phase machine: one wait state before every answer
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         st_idle:
         begin
            if (access_phase)
               state_next = st_ready;
         end
         st_ready:
         begin
            state_next = st_idle;
         end
         default:
         begin
            state_next = st_idle;
         end
      endcase
   end

   // phase register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= st_idle;
      else
         state_reg <= state_next;
   end

   // read multiplexer; unmapped addresses read as zero
   always_comb
   begin
      read_mux = 32'h0000_0000;
      if (hit_cfg4)
         read_mux[7:0] = cfg4_reg; // RULE5
      else if (hit_test_one)
         read_mux[7:0] = factory_test_one_reg; // RULE7
      else if (hit_test_two)
         read_mux[7:0] = factory_test_two_reg; // RULE7
      else if (hit_lock)
      begin
         read_mux[`LOCK_BIT] = lock_reg;
         read_mux[`LOCK_PIN_LEVEL_BIT] = pin_level_reg;
      end
      else if (hit_status)
         read_mux[`EVENT_WIDTH-1:0] = status_reg;
      else if (hit_mask)
         read_mux[`EVENT_WIDTH-1:0] = mask_reg;
   end

   // answer signals, all registered so the bus sees clean flop outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else if (state_next == st_ready)
      begin
         pready_reg <= 1'b1;
         pslverr_reg <= !mapped;
         prdata_reg <= pwrite ? 32'h0000_0000 : read_mux;
      end
      else
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // pin function and tach threshold; all zero out of reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg4_reg <= `CFG4_RESET; // RULE6
      else if (cfg4_write)
         cfg4_reg <= cfg4_merged; // RULE4 RULE5
   end

   // factory test registers: never written, so a stray write is harmless
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         factory_test_one_reg <= `FACTORY_TEST_RESET; // RULE7
         factory_test_two_reg <= `FACTORY_TEST_RESET; // RULE7
      end
   end

   // lock is set-only; only a reset reopens the configuration register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_reg <= `LOCK_RESET;
      else if (wr_commit && hit_lock && lane0 && pwdata[`LOCK_BIT])
         lock_reg <= 1'b1; // RULE4
   end

   // interrupt mask, one enables the matching status flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_reg <= `EVENT_MASK_RESET;
      else if (wr_commit && hit_mask)
      begin
         if (lane0)
            mask_reg[7:0] <= pwdata[7:0];
         if (lane1)
            mask_reg[8] <= pwdata[8];
      end
   end

   // event sources: limit inputs and refused configuration writes
   always_comb
   begin
      event_set = {`EVENT_WIDTH{1'b0}};
      event_set[`LIMIT_WIDTH-1:0] = limit_flags;
      event_set[`EVENT_BLOCKED_WRITE] = cfg4_blocked;
   end

   // write-one-to-clear strobes per byte lane
   always_comb
   begin
      event_clear = {`EVENT_WIDTH{1'b0}};
      if (wr_commit && hit_status)
      begin
         if (lane0)
            event_clear[7:0] = pwdata[7:0];
         if (lane1)
            event_clear[8] = pwdata[8];
      end
   end

   // sticky flag storage
   sticky_event_bank u_events (
      .pclk(pclk),
      .presetn(presetn),
      .event_set(event_set),
      .event_clear(event_clear),
      .status_reg(status_reg)
   );

   assign pending = |(status_reg & mask_reg);

   // interrupt line follows enabled flags one edge later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= pending;
   end

   // open-drain alert: pull low only in alert mode with a pending flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         alert_oe_reg <= 1'b0;
      else if (cfg4_reg[`CFG4_ALERT_BIT])
         alert_oe_reg <= pending; // RULE1 RULE8
      else
         alert_oe_reg <= 1'b0; // RULE2
   end

   // measurement path enabled only while the pin is not an alert
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         meas_en_reg <= 1'b1; // RULE6
      else
         meas_en_reg <= !cfg4_reg[`CFG4_ALERT_BIT]; // RULE2
   end

   // threshold code to the analog front end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         thr_reg <= 2'b00; // RULE6
      else
         thr_reg <= cfg4_reg[`CFG4_THR_MSB:`CFG4_THR_LSB]; // RULE3
   end

   // millivolt value of the selected threshold
   tach_threshold_decode u_thr (
      .pclk(pclk),
      .presetn(presetn),
      .thr_code(tach_thr_t'(cfg4_reg[`CFG4_THR_MSB:`CFG4_THR_LSB])),
      .thr_mv_reg(tach_threshold_mv)
   );

   // pin level snapshot for software; other drivers may share the wire
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_level_reg <= 1'b1;
      else
         pin_level_reg <= alert_pin_in;
   end

   // outputs straight from flops; the drive value is always low
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign alert_pin_out = 1'b0; // RULE8
   assign alert_pin_oe = alert_oe_reg;
   assign meas_2v5_enable = meas_en_reg;
   assign two_wire_tach_threshold = thr_reg;
   assign irq = irq_reg;

endmodule

// >>> hdl/cfg4_regs_consts.svh
// constants for the pin/tach configuration register bank
`ifndef CFG4_REGS_CONSTS_SVH
`define CFG4_REGS_CONSTS_SVH

// printed register indices; byte address is four times the index
`define IDX_PIN_TACH_CFG 10'h07d
`define IDX_FACTORY_TEST_ONE 10'h07e
`define IDX_FACTORY_TEST_TWO 10'h07f
`define IDX_LOCK_CONTROL 10'h070
`define IDX_EVENT_STATUS 10'h071
`define IDX_EVENT_MASK 10'h072

// field positions in the pin/tach configuration register
`define CFG4_ALERT_BIT 0
`define CFG4_THR_LSB 2
`define CFG4_THR_MSB 3
`define CFG4_WMASK 8'h0d

// field positions in the lock control register
`define LOCK_BIT 0
`define LOCK_PIN_LEVEL_BIT 1

// reset values
`define CFG4_RESET 8'h00
`define FACTORY_TEST_RESET 8'h00
`define LOCK_RESET 1'b0
`define EVENT_MASK_RESET 9'h000

// event bank layout: eight limit flags plus a blocked-write flag
`define EVENT_WIDTH 9
`define LIMIT_WIDTH 8
`define EVENT_BLOCKED_WRITE 8

// tach threshold magnitudes in millivolts
`define THR_MV_00 8'h14
`define THR_MV_01 8'h28
`define THR_MV_10 8'h50
`define THR_MV_11 8'h82

`endif

// >>> hdl/cfg4_regs_pkg.sv
// types shared by the pin/tach configuration register bank
package cfg4_regs_pkg;

   // apb slave phases, gray coded
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_ready = 2'b01
   } apb_state_t;

   // tach input threshold selection
   typedef enum logic [1:0] {
      thr_20mv = 2'b00,
      thr_40mv = 2'b01,
      thr_80mv = 2'b10,
      thr_130mv = 2'b11
   } tach_thr_t;

   typedef logic [7:0] byte_t;

endpackage

// >>> hdl/sticky_event_bank.sv
// sticky event flags, cleared by writing one, set wins over clear
`timescale 1ns/100ps
`include "cfg4_regs_consts.svh"

module sticky_event_bank
   import cfg4_regs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`EVENT_WIDTH-1:0] event_set,
   input wire logic [`EVENT_WIDTH-1:0] event_clear,
   output logic [`EVENT_WIDTH-1:0] status_reg
);

   genvar i;

   // one flop per flag; an event in the clear cycle is kept
   generate
      for (i = 0; i < `EVENT_WIDTH; i = i + 1)
      begin : g_flag
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               status_reg[i] <= 1'b0;
            else if (event_set[i])
               status_reg[i] <= 1'b1;
            else if (event_clear[i])
               status_reg[i] <= 1'b0;
         end
      end
   endgenerate

endmodule

// >>> hdl/tach_threshold_decode.sv
// registered millivolt decode of the tach input threshold code
`timescale 1ns/100ps
`include "cfg4_regs_consts.svh"

module tach_threshold_decode
   import cfg4_regs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire tach_thr_t thr_code,
   output logic [7:0] thr_mv_reg
);

   // lookup of the comparator magnitude for the analog front end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         thr_mv_reg <= `THR_MV_00;
      else
      begin
         case (thr_code)
            thr_20mv: thr_mv_reg <= `THR_MV_00; // RULE3
            thr_40mv: thr_mv_reg <= `THR_MV_01; // RULE3
            thr_80mv: thr_mv_reg <= `THR_MV_10; // RULE3
            thr_130mv: thr_mv_reg <= `THR_MV_11; // RULE3
            default: thr_mv_reg <= `THR_MV_00;
         endcase
      end
   end

endmodule

// >>> test/cfg4_regs_sva.sv
// port assertions for the pin/tach configuration register bank
`timescale 1ns/100ps
`include "cfg4_regs_consts.svh"

module cfg4_regs_sva
   import cfg4_regs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [`LIMIT_WIDTH-1:0] limit_flags,
   input wire logic alert_pin_in,
   input wire logic alert_pin_out,
   input wire logic alert_pin_oe,
   input wire logic meas_2v5_enable,
   input wire logic [1:0] two_wire_tach_threshold,
   input wire logic [7:0] tach_threshold_mv,
   input wire logic irq
);
   logic lock_seen;
   wire done = psel && penable && pready;

   // lock is set-only, so a sticky copy here mirrors it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_seen <= 1'b0;
      else if (done && pwrite && !pslverr && pstrb[0] && pwdata[0]
         && paddr == {`IDX_LOCK_CONTROL, 2'b00})
         lock_seen <= 1'b1;
   end

   function automatic logic [7:0] mv_of(input logic [1:0] c);
      return c == 2'b00 ? `THR_MV_00 : c == 2'b01 ? `THR_MV_01
         : c == 2'b10 ? `THR_MV_10 : `THR_MV_11;
   endfunction

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // decode is registered, so only judge it once the code has settled
   sequence thr_held;
      $stable(two_wire_tach_threshold) [*2];
   endsequence
   sequence access_start;
      psel && $rose(penable);
   endsequence

   a_oe_follows_irq: assert property (alert_pin_oe == (irq && !meas_2v5_enable))
      else $error("alert drive does not follow masked events");
   a_no_alert_meas: assert property (meas_2v5_enable |-> !alert_pin_oe)
      else $error("alert driven in measurement mode");
   a_drive_low: assert property (alert_pin_out == 1'b0)
      else $error("open-drain drive value not low");
   a_mv_decode: assert property (thr_held
      |-> tach_threshold_mv == mv_of(two_wire_tach_threshold))
      else $error("threshold millivolt decode wrong");
   a_ready_one_wait: assert property (access_start |=> pready)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_cfg_reserved: assert property (done && !pwrite && !pslverr
      && paddr == {`IDX_PIN_TACH_CFG, 2'b00} |-> prdata[1] == 1'b0 && prdata[31:4] == 28'h0000000)
      else $error("reserved config bits read nonzero");
   a_test_zero: assert property (done && !pwrite
      && (paddr == {`IDX_FACTORY_TEST_ONE, 2'b00} || paddr == {`IDX_FACTORY_TEST_TWO, 2'b00})
      |-> prdata == 32'h0 && !pslverr)
      else $error("test register read not zero");
   a_locked_frozen: assert property (lock_seen
      |-> $stable(two_wire_tach_threshold) && $stable(meas_2v5_enable))
      else $error("config changed while locked");
endmodule

// >>> test/config_four_and_test_regs_tb_top.sv
// self-checking bench for the pin/tach configuration register bank
`timescale 1ns/100ps
`include "cfg4_regs_consts.svh"

module config_four_and_test_regs_tb_top;
   localparam logic [11:0] A_CFG = {`IDX_PIN_TACH_CFG, 2'b00};
   localparam logic [11:0] A_T1 = {`IDX_FACTORY_TEST_ONE, 2'b00};
   localparam logic [11:0] A_T2 = {`IDX_FACTORY_TEST_TWO, 2'b00};
   localparam logic [11:0] A_LCK = {`IDX_LOCK_CONTROL, 2'b00};
   localparam logic [11:0] A_ST = {`IDX_EVENT_STATUS, 2'b00};
   localparam logic [11:0] A_MK = {`IDX_EVENT_MASK, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic ext_low = 1'b0;
   logic rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdata;
   logic [3:0] pstrb = 4'hf;
   logic [7:0] limit_flags = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, alert_pin_out, alert_pin_oe, meas, irq;
   logic [1:0] thr;
   logic [7:0] mv;
   wire alert_pin_in;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;

   // open-drain pin with pull-up; ext_low is another party pulling it down
   assign alert_pin_in = !(alert_pin_oe || ext_low);

   config_four_and_test_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .limit_flags(limit_flags),
      .alert_pin_in(alert_pin_in), .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe),
      .meas_2v5_enable(meas), .two_wire_tach_threshold(thr), .tach_threshold_mv(mv), .irq(irq));

   always #5 pclk = ~pclk;

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task report_and_stop();
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask

   // outputs are registered copies, one edge behind the register
   task settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task pulse(input logic [7:0] f);
      @(posedge pclk);
      limit_flags <= f;
      @(posedge pclk);
      limit_flags <= 8'h00;
      settle();
   endtask

   task t_reset();
      settle();
      chk({meas, thr, mv}, {1'b1, 2'b00, 8'h14});
      rdc(A_CFG, 32'h0);
      rdc(A_T1, 32'h0);
      rdc(A_T2, 32'h0);
      rdc(A_MK, 32'h0);
   endtask

   task t_thresh();
      logic [7:0] tab [4];
      tab = '{8'h14, 8'h28, 8'h50, 8'h82};
      for (int i = 0; i < 4; i++)
      begin
         wr(A_CFG, 32'hf2 | (i << 2));
         settle();
         chk(thr, i);
         chk(mv, tab[i]);
         rdc(A_CFG, i << 2);
      end
   endtask

   task t_alert();
      wr(A_CFG, 32'h1);
      wr(A_MK, 32'h1);
      pulse(8'h01);
      chk({irq, alert_pin_oe, meas}, 3'b110);
      rdc(A_LCK, 32'h0);
      rdc(A_ST, 32'h1);
      wr(A_ST, 32'h1);
      settle();
      chk({irq, alert_pin_oe}, 2'b00);
      pulse(8'h02);
      chk({irq, alert_pin_oe}, 2'b00);
      wr(A_MK, 32'h2);
      settle();
      chk({irq, alert_pin_oe}, 2'b11);
      wr(A_CFG, 32'h0);
      settle();
      chk({irq, alert_pin_oe, meas}, 3'b101);
      wr(A_ST, 32'h2);
      @(posedge pclk);
      ext_low <= 1'b1;
      settle();
      rdc(A_LCK, 32'h0);
      ext_low <= 1'b0;
      settle();
      rdc(A_LCK, 32'h2);
   endtask

   task t_refuse();
      wr(A_T1, 32'hff);
      chk(rerr, 1'b0);
      rdc(A_T1, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({rerr, rdata}, {1'b1, 32'h0});
      wr(A_CFG + 12'h1, 32'hc);
      chk(rerr, 1'b1);
      rdc(A_CFG, 32'h0);
      // a write without the low byte lane must not reach the register
      pstrb <= 4'he;
      wr(A_CFG, 32'h4);
      chk(rerr, 1'b0);
      pstrb <= 4'hf;
      rdc(A_CFG, 32'h0);
   endtask

   task t_lock();
      wr(A_CFG, 32'h4);
      wr(A_LCK, 32'h1);
      wr(A_MK, 32'h100);
      wr(A_CFG, 32'hd);
      settle();
      rdc(A_CFG, 32'h4);
      chk({thr, irq}, 3'b011);
      rdc(A_ST, 32'h100);
      wr(A_LCK, 32'h0);
      wr(A_CFG, 32'h8);
      rdc(A_CFG, 32'h4);
      rdc(A_LCK, 32'h3);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_CFG, 32'h0);
      wr(A_CFG, 32'h8);
      rdc(A_CFG, 32'h8);
   endtask

   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_thresh();
      t_alert();
      t_refuse();
      t_lock();
      report_and_stop();
   end
endmodule

bind config_four_and_test_regs cfg4_regs_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .limit_flags(limit_flags),
   .alert_pin_in(alert_pin_in), .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe),
   .meas_2v5_enable(meas_2v5_enable), .two_wire_tach_threshold(two_wire_tach_threshold),
   .tach_threshold_mv(tach_threshold_mv), .irq(irq));
